// ==== pin_function_select_and_drive.sv ====
// register block that picks pin functions and source drive levels
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "pinsel_cfg.svh"
module pin_function_select_and_drive (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output pinsel_pkg::drive_out_t drive_levels,
	output pinsel_pkg::porta_route_t porta_route,
	output logic [7:0] output_function_select_regs [0:11],
	output logic [7:0] input_source_select_regs [0:2]
);
	logic [7:0] regs_q [0:`NUM_REGS-1];
	logic [31:0] prdata_q;
	logic pslverr_q;
	pinsel_pkg::apb_phase_t phase;

	function automatic logic [7:0] impl_mask(input logic [4:0] idx);
		case (idx)
			5'h03: impl_mask = `PAS_LO_MASK;
			5'h06: impl_mask = `PBS_HI_MASK;
			5'h0A: impl_mask = `PDS_HI_MASK;
			5'h0C: impl_mask = `PES_HI_MASK;
			5'h0F: impl_mask = `IFS_TMR_MASK;
			5'h10: impl_mask = `IFS_SER_MASK;
			5'h11: impl_mask = `IFS_UART_MASK;
			default: impl_mask = 8'hFF;
		endcase
	endfunction : impl_mask

	function automatic logic is_alt(input logic [1:0] code);
		is_alt = (code == `CODE_ALT);
	endfunction : is_alt

	wire logic [4:0] idx = paddr[6:2] + 5'h01;
	wire logic hit = (paddr[1:0] == 2'h0) && (paddr[11:7] == 5'h00) && (idx >= 5'h01) && (idx <= 5'h11);
	wire logic [4:0] sel = hit ? idx - 5'h01 : 5'h00;
	wire logic acc = psel && penable;
	wire logic wr_en = acc && pwrite && hit && pstrb[0];
	wire logic [7:0] mask = impl_mask(idx);
	wire logic [7:0] rd_byte = regs_q[sel] & mask;

	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign phase = !psel ? pinsel_pkg::APB_IDLE : (penable ? pinsel_pkg::APB_ACCESS : pinsel_pkg::APB_SETUP);

	// register array, unimplemented bits held at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `NUM_REGS; i++) begin
				regs_q[i] <= `RST_VAL;
			end
		end else if (wr_en) begin
			regs_q[sel] <= pwdata[7:0] & mask;
		end
	end

	// read data and error registered at the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (phase == pinsel_pkg::APB_SETUP) begin
			prdata_q <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr_q <= !hit;
		end else begin
			prdata_q <= prdata_q;
			pslverr_q <= pslverr_q;
		end
	end

	// drive level fields
	assign drive_levels.pc30 = pinsel_pkg::drive_level_t'(regs_q[0][`FIELD_PC30]);
	assign drive_levels.pf74 = pinsel_pkg::drive_level_t'(regs_q[1][`FIELD_PF74]);
	assign drive_levels.pf30 = pinsel_pkg::drive_level_t'(regs_q[1][`FIELD_PF30]);
	assign drive_levels.pe4 = pinsel_pkg::drive_level_t'(regs_q[1][`FIELD_PE4]);
	assign drive_levels.pe30 = pinsel_pkg::drive_level_t'(regs_q[1][`FIELD_PE30]);

	// port A routing
	assign porta_route.pa3_spi_sdo = is_alt(regs_q[2][`FIELD_PA3]);
	assign porta_route.pa3_irq_one = !is_alt(regs_q[2][`FIELD_PA3]);
	assign porta_route.pa1_spi_cs = is_alt(regs_q[2][`FIELD_PA1]);
	assign porta_route.pa1_irq_zero = !is_alt(regs_q[2][`FIELD_PA1]);
	assign porta_route.pa7_uart_zero_tx = is_alt(regs_q[3][`FIELD_PA7]);
	assign porta_route.pa7_irq_one = !is_alt(regs_q[3][`FIELD_PA7]);

	// raw select registers to the pin and peripheral muxes
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			output_function_select_regs[i] = regs_q[i+2];
		end
		for (int j = 0; j < 3; j++) begin
			input_source_select_regs[j] = regs_q[j+14];
		end
	end

	property p_write_lands;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && pstrb[0]) |=> (regs_q[$past(sel)] == ($past(pwdata[7:0]) & $past(mask)));
	endproperty
	AST_WRITE_LANDS: assert property (p_write_lands) else $error("register write lost");

	AST_PAS_LO_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		regs_q[2][5:4] == 2'h0) else $error("unimplemented bits 5-4 set");
	AST_PAS_LO_ZERO_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		regs_q[2][1:0] == 2'h0) else $error("unimplemented bits 1-0 set");
	AST_PA3_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
		porta_route.pa3_spi_sdo == (regs_q[2][7:6] == 2'h3) && porta_route.pa3_irq_one != porta_route.pa3_spi_sdo)
		else $error("pa3 route wrong");
	AST_PA1_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
		porta_route.pa1_spi_cs == (regs_q[2][3:2] == 2'h3) && porta_route.pa1_irq_zero != porta_route.pa1_spi_cs)
		else $error("pa1 route wrong");
	AST_PA7_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
		porta_route.pa7_uart_zero_tx == (regs_q[3][7:6] == 2'h3) && porta_route.pa7_irq_one != porta_route.pa7_uart_zero_tx)
		else $error("pa7 route wrong");
	AST_PC_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h00) |=> drive_levels.pc30 == $past(pwdata[1:0])) else $error("pc drive not updated");
	AST_EF_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h01) |=> {drive_levels.pf74, drive_levels.pf30, drive_levels.pe4, drive_levels.pe30}
		== $past(pwdata[7:0])) else $error("ef drive not updated");
	AST_LEVEL_MAX: assert property (@(posedge pclk) disable iff (!presetn)
		(regs_q[0][1:0] == 2'h3) |-> drive_levels.pc30 == pinsel_pkg::DRV_LEVEL3) else $error("level map wrong");

	// bus transfer steps as this slave sees them
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_access;
		psel && penable;
	endsequence

	sequence s_read_setup;
		psel && !penable && !pwrite;
	endsequence

	sequence s_pas_lo_read;
		psel && !penable && !pwrite && hit && (sel == 5'h02);
	endsequence

	property p_ready_high;
		@(posedge pclk) disable iff (!presetn)
		pready == 1'b1;
	endproperty
	AST_READY_HIGH: assert property (p_ready_high) else $error("ready not high");

	property p_rd_data;
		@(posedge pclk) disable iff (!presetn)
		(s_read_setup ##1 s_access) |-> prdata == ($past(hit) ? {24'h00_0000, $past(rd_byte)} : 32'h0000_0000);
	endproperty
	AST_RD_DATA: assert property (p_rd_data) else $error("read data wrong");

	property p_rd_upper_zero;
		@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h00_0000;
	endproperty
	AST_RD_UPPER_ZERO: assert property (p_rd_upper_zero) else $error("read data upper bits set");

	property p_err_value;
		@(posedge pclk) disable iff (!presetn)
		(s_setup ##1 s_access) |-> pslverr == !$past(hit);
	endproperty
	AST_ERR_VALUE: assert property (p_err_value) else $error("error response wrong");

	property p_rd_hold;
		@(posedge pclk) disable iff (!presetn)
		(!psel || penable) |=> $stable(prdata);
	endproperty
	AST_RD_HOLD: assert property (p_rd_hold) else $error("read data moved");

	property p_err_hold;
		@(posedge pclk) disable iff (!presetn)
		(!psel || penable) |=> $stable(pslverr);
	endproperty
	AST_ERR_HOLD: assert property (p_err_hold) else $error("error response moved");

	property p_unmapped_read_zero;
		@(posedge pclk) disable iff (!presetn)
		(s_setup ##1 s_access) |-> ($past(hit) || prdata == 32'h0000_0000);
	endproperty
	AST_UNMAPPED_READ_ZERO: assert property (p_unmapped_read_zero) else $error("unmapped read not zero");

	property p_no_write_read;
		@(posedge pclk) disable iff (!presetn)
		(acc && !pwrite) |=> regs_q[$past(sel)] == $past(regs_q[sel]);
	endproperty
	AST_NO_WRITE_READ: assert property (p_no_write_read) else $error("read changed a register");

	property p_no_write_strb;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && hit && !pstrb[0]) |=> regs_q[$past(sel)] == $past(regs_q[sel]);
	endproperty
	AST_NO_WRITE_STRB: assert property (p_no_write_strb) else $error("write without strobe landed");

	property p_no_write_unmapped;
		@(posedge pclk) disable iff (!presetn)
		(acc && pwrite && !hit) |=> regs_q[0] == $past(regs_q[0]);
	endproperty
	AST_NO_WRITE_UNMAPPED: assert property (p_no_write_unmapped) else $error("unmapped write landed");

	property p_pas_lo_write_mask;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h02) |=> regs_q[2] == ($past(pwdata[7:0]) & `PAS_LO_MASK);
	endproperty
	AST_PAS_LO_WRITE_MASK: assert property (p_pas_lo_write_mask) else $error("port a low mask wrong");

	property p_pas_lo_read_hi;
		@(posedge pclk) disable iff (!presetn)
		(s_pas_lo_read ##1 s_access) |-> prdata[5:4] == 2'h0;
	endproperty
	AST_PAS_LO_READ_HI: assert property (p_pas_lo_read_hi) else $error("bits 5-4 read nonzero");

	property p_pas_lo_read_lo;
		@(posedge pclk) disable iff (!presetn)
		(s_pas_lo_read ##1 s_access) |-> prdata[1:0] == 2'h0;
	endproperty
	AST_PAS_LO_READ_LO: assert property (p_pas_lo_read_lo) else $error("bits 1-0 read nonzero");

	property p_pbs_hi_zero;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[5] & ~`PBS_HI_MASK) == 8'h00;
	endproperty
	AST_PBS_HI_ZERO: assert property (p_pbs_hi_zero) else $error("port b high spare bits set");

	property p_pds_hi_zero;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[9] & ~`PDS_HI_MASK) == 8'h00;
	endproperty
	AST_PDS_HI_ZERO: assert property (p_pds_hi_zero) else $error("port d high spare bits set");

	property p_pes_hi_zero;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[11] & ~`PES_HI_MASK) == 8'h00;
	endproperty
	AST_PES_HI_ZERO: assert property (p_pes_hi_zero) else $error("port e high spare bits set");

	property p_ifs_tmr_zero;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[14] & ~`IFS_TMR_MASK) == 8'h00;
	endproperty
	AST_IFS_TMR_ZERO: assert property (p_ifs_tmr_zero) else $error("timer source spare bits set");

	property p_ifs_ser_zero;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[15] & ~`IFS_SER_MASK) == 8'h00;
	endproperty
	AST_IFS_SER_ZERO: assert property (p_ifs_ser_zero) else $error("serial source spare bits set");

	property p_ifs_uart_zero;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[16] & ~`IFS_UART_MASK) == 8'h00;
	endproperty
	AST_IFS_UART_ZERO: assert property (p_ifs_uart_zero) else $error("uart source spare bits set");

	property p_pa3_sdo_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h02 && pwdata[7:6] == 2'h3) |=> porta_route.pa3_spi_sdo;
	endproperty
	AST_PA3_SDO_SET: assert property (p_pa3_sdo_set) else $error("pa3 data out not selected");

	property p_pa3_irq_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h02 && pwdata[7:6] != 2'h3) |=> porta_route.pa3_irq_one;
	endproperty
	AST_PA3_IRQ_SET: assert property (p_pa3_irq_set) else $error("pa3 irq not selected");

	property p_pa1_cs_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h02 && pwdata[3:2] == 2'h3) |=> porta_route.pa1_spi_cs;
	endproperty
	AST_PA1_CS_SET: assert property (p_pa1_cs_set) else $error("pa1 chip select not selected");

	property p_pa1_irq_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h02 && pwdata[3:2] != 2'h3) |=> porta_route.pa1_irq_zero;
	endproperty
	AST_PA1_IRQ_SET: assert property (p_pa1_irq_set) else $error("pa1 irq not selected");

	property p_pa7_tx_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h03 && pwdata[7:6] == 2'h3) |=> porta_route.pa7_uart_zero_tx;
	endproperty
	AST_PA7_TX_SET: assert property (p_pa7_tx_set) else $error("pa7 transmit not selected");

	property p_pa7_irq_set;
		@(posedge pclk) disable iff (!presetn)
		(wr_en && sel == 5'h03 && pwdata[7:6] != 2'h3) |=> porta_route.pa7_irq_one;
	endproperty
	AST_PA7_IRQ_SET: assert property (p_pa7_irq_set) else $error("pa7 irq not selected");

	property p_pf74_field;
		@(posedge pclk) disable iff (!presetn)
		drive_levels.pf74 == regs_q[1][7:6];
	endproperty
	AST_PF74_FIELD: assert property (p_pf74_field) else $error("pf74 level wrong");

	property p_pf30_field;
		@(posedge pclk) disable iff (!presetn)
		drive_levels.pf30 == regs_q[1][5:4];
	endproperty
	AST_PF30_FIELD: assert property (p_pf30_field) else $error("pf30 level wrong");

	property p_pe4_field;
		@(posedge pclk) disable iff (!presetn)
		drive_levels.pe4 == regs_q[1][3:2];
	endproperty
	AST_PE4_FIELD: assert property (p_pe4_field) else $error("pe4 level wrong");

	property p_pe30_field;
		@(posedge pclk) disable iff (!presetn)
		drive_levels.pe30 == regs_q[1][1:0];
	endproperty
	AST_PE30_FIELD: assert property (p_pe30_field) else $error("pe30 level wrong");

	property p_pc30_field;
		@(posedge pclk) disable iff (!presetn)
		drive_levels.pc30 == regs_q[0][1:0];
	endproperty
	AST_PC30_FIELD: assert property (p_pc30_field) else $error("pc30 level wrong");

	property p_osel_first;
		@(posedge pclk) disable iff (!presetn)
		output_function_select_regs[0] == regs_q[2];
	endproperty
	AST_OSEL_FIRST: assert property (p_osel_first) else $error("first output select wrong");

	property p_osel_last;
		@(posedge pclk) disable iff (!presetn)
		output_function_select_regs[11] == regs_q[13];
	endproperty
	AST_OSEL_LAST: assert property (p_osel_last) else $error("last output select wrong");

	property p_isel_first;
		@(posedge pclk) disable iff (!presetn)
		input_source_select_regs[0] == regs_q[14];
	endproperty
	AST_ISEL_FIRST: assert property (p_isel_first) else $error("first input source wrong");

	property p_isel_last;
		@(posedge pclk) disable iff (!presetn)
		input_source_select_regs[2] == regs_q[16];
	endproperty
	AST_ISEL_LAST: assert property (p_isel_last) else $error("last input source wrong");

	property p_level_min;
		@(posedge pclk) disable iff (!presetn)
		(regs_q[0][1:0] == 2'h0) |-> drive_levels.pc30 == pinsel_pkg::DRV_LEVEL0;
	endproperty
	AST_LEVEL_MIN: assert property (p_level_min) else $error("minimum level map wrong");

endmodule : pin_function_select_and_drive

// ==== pinsel_cfg.svh ====
// constants for the pin function select and drive block
// Notes on behaviour
// - low two bits of first drive register set port C pins 3-0 current
// - drive field is binary: 00 level 0 minimum up to 11 level 3 maximum
// - per-port output select and input source select registers exist
// - port A pin 3: codes 00-10 general I/O with irq one, 11 serial data out
// - port A pin 1: codes 00-10 general I/O with irq zero, 11 serial chip select
// - first port A select bits 5-4 unimplemented, read zero
// - first port A select bits 1-0 unimplemented, read zero
// - port A pin 7: codes 00-10 general I/O with irq one, 11 uart zero transmit
`ifndef PINSEL_CFG_SVH
`define PINSEL_CFG_SVH
`define OFS_DRV_CD 12'h000
`define OFS_DRV_EF 12'h004
`define OFS_PAS_LO 12'h008
`define OFS_PAS_HI 12'h00C
`define OFS_PBS_LO 12'h010
`define OFS_PBS_HI 12'h014
`define OFS_PCS_LO 12'h018
`define OFS_PCS_HI 12'h01C
`define OFS_PDS_LO 12'h020
`define OFS_PDS_HI 12'h024
`define OFS_PES_LO 12'h028
`define OFS_PES_HI 12'h02C
`define OFS_PFS_LO 12'h030
`define OFS_PFS_HI 12'h034
`define OFS_IFS_TMR 12'h038
`define OFS_IFS_SER 12'h03C
`define OFS_IFS_UART 12'h040
`define NUM_REGS 17
`define RST_VAL 8'h00
`define PAS_LO_MASK 8'hCC
`define PBS_HI_MASK 8'hF3
`define PDS_HI_MASK 8'h3F
`define PES_HI_MASK 8'h03
`define IFS_TMR_MASK 8'h7F
`define IFS_SER_MASK 8'h7F
`define IFS_UART_MASK 8'h07
`define FIELD_PC30 1:0
`define FIELD_PF74 7:6
`define FIELD_PF30 5:4
`define FIELD_PE4 3:2
`define FIELD_PE30 1:0
`define FIELD_PA3 7:6
`define FIELD_PA1 3:2
`define FIELD_PA7 7:6
`define CODE_ALT 2'h3
`endif

// ==== pinsel_pkg.sv ====
// types for the pin function select and drive block
package pinsel_pkg;
	typedef enum logic [1:0] {
		DRV_LEVEL0,
		DRV_LEVEL1,
		DRV_LEVEL2,
		DRV_LEVEL3
	} drive_level_t;
	typedef struct packed {
		drive_level_t pc30;
		drive_level_t pf74;
		drive_level_t pf30;
		drive_level_t pe4;
		drive_level_t pe30;
	} drive_out_t;
	typedef struct packed {
		logic pa3_spi_sdo;
		logic pa3_irq_one;
		logic pa1_spi_cs;
		logic pa1_irq_zero;
		logic pa7_uart_zero_tx;
		logic pa7_irq_one;
	} porta_route_t;
	typedef enum logic [1:0] {
		APB_IDLE,
		APB_SETUP,
		APB_ACCESS
	} apb_phase_t;
endpackage : pinsel_pkg

// ==== testbench.sv ====
// self-checking bench for the pin function select and drive block
`timescale 1ns/1ps
`include "pinsel_cfg.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", n, e, a); end end
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic [7:0] osel [0:11];
	logic [7:0] isel [0:2];
	pinsel_pkg::drive_out_t drv;
	pinsel_pkg::porta_route_t rte;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r;} row_t;
	row_t rows [9] = '{'{`OFS_DRV_CD, 8'hA7, 8'hA7}, '{`OFS_DRV_EF, 8'h1B, 8'h1B}, '{`OFS_PAS_LO, 8'hFF, 8'hCC},
		'{`OFS_PAS_HI, 8'h80, 8'h80}, '{`OFS_PBS_HI, 8'hFF, 8'hF3}, '{`OFS_PDS_HI, 8'hFF, 8'h3F},
		'{`OFS_PES_HI, 8'hFF, 8'h03}, '{`OFS_IFS_TMR, 8'hFF, 8'h7F}, '{`OFS_IFS_UART, 8'hFF, 8'h07}};
	pin_function_select_and_drive uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive_levels(drv), .porta_route(rte), .output_function_select_regs(osel),
		.input_source_select_regs(isel));
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			results();
		end
	end
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic results();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < `NUM_REGS; i++) begin
			apb(1'b0, 12'(4 * i), 8'h00);
			`CHK("reset value", 32'h0, rd)
		end
		`CHK("reset routes", 6'b010101, rte)
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].w);
			apb(1'b0, rows[i].a, 8'h00);
			`CHK("readback", {24'h0, rows[i].r}, rd)
			`CHK("mapped err", 1'b0, err)
		end
		$display("test table done");
		`CHK("pc30", pinsel_pkg::DRV_LEVEL3, drv.pc30)
		`CHK("pe4", pinsel_pkg::DRV_LEVEL2, drv.pe4)
		`CHK("ef fields", 8'h1B, {drv.pf74, drv.pf30, drv.pe4, drv.pe30})
		`CHK("pa3 alt", 2'b10, {rte.pa3_spi_sdo, rte.pa3_irq_one})
		`CHK("pa1 alt", 2'b10, {rte.pa1_spi_cs, rte.pa1_irq_zero})
		`CHK("pa7 code 10", 2'b01, {rte.pa7_uart_zero_tx, rte.pa7_irq_one})
		`CHK("pa lo bits", 8'hCC, osel[0])
		`CHK("uart source", 8'h07, isel[2])
		apb(1'b1, `OFS_PAS_LO, 8'h88);
		`CHK("pa code 10", 4'b0101, {rte.pa3_spi_sdo, rte.pa3_irq_one, rte.pa1_spi_cs, rte.pa1_irq_zero})
		apb(1'b1, `OFS_PAS_HI, 8'hC0);
		`CHK("pa7 uart", 2'b10, {rte.pa7_uart_zero_tx, rte.pa7_irq_one})
		apb(1'b1, 12'h044, 8'hFF);
		`CHK("unmapped err", 1'b1, err)
		pstrb <= 4'h0;
		apb(1'b1, `OFS_DRV_CD, 8'h00);
		pstrb <= 4'hF;
		`CHK("no strobe", pinsel_pkg::DRV_LEVEL3, drv.pc30)
		$display("test awkward done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("drive after reset", 10'h000, drv)
		`CHK("pa lo after reset", 8'h00, osel[0])
		$display("test second reset done");
		results();
	end
endmodule : testbench
